// ### logic/sscr_pkg.sv
// Shared constants for the state sensor command responder.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package sscr_pkg;
    // ========================================
    // Sizes
    localparam int unsigned NUM_SUB_MAX = 8;
    localparam int unsigned REC_W = 24;

    // ========================================
    // Handles, counts and result codes
    localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
    localparam logic [15:0] HANDLE_RSVD_HI = 16'hFFFF;
    localparam logic [7:0] COUNT_MIN = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'h08;
    localparam logic [7:0] RC_SUCCESS = 8'h00;
    localparam logic [7:0] RC_INVALID_DATA = 8'h02;
    localparam logic [7:0] RC_UNKNOWN_HANDLE = 8'h80;

    // ========================================
    // Field encodings
    localparam logic [7:0] OPC_ENABLED = 8'h00;
    localparam logic [7:0] OPC_DISABLED = 8'h01;
    localparam logic [7:0] OPC_UNAVAILABLE = 8'h02;
    localparam logic [7:0] NOTIFY_OFF = 8'h00;
    localparam logic [7:0] NOTIFY_ON = 8'h01;
    localparam logic [7:0] NOTIFY_KEEP = 8'hFF;
    localparam logic [7:0] STATE_UNKNOWN = 8'h00;

    // ========================================
    // Register byte offsets and field positions
    localparam logic [7:0] ADDR_SETUP_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_READ_CMD = 8'h08;
    localparam logic [2:0] ADDR_REC_REGION = 3'h1;
    localparam logic [2:0] ADDR_STATE_REGION = 3'h2;
    localparam int unsigned CMD_COUNT_LSB = 16;
    localparam int unsigned CMD_GO_BIT = 31;
    localparam int unsigned RDCMD_MASK_LSB = 16;
    localparam int unsigned REC_COND_LSB = 0;
    localparam int unsigned REC_INIT_LSB = 8;
    localparam int unsigned REC_NOTIFY_LSB = 16;
    localparam int unsigned STATUS_BUSY_BIT = 8;
    localparam int unsigned STATUS_RDRC_LSB = 16;
    localparam int unsigned STATUS_NSUB_LSB = 24;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_COND = OPC_ENABLED;
    localparam logic RST_NOTIFY_EN = 1'b0;

    typedef enum logic [1:0] {
        SSCR_IDLE,
        SSCR_CHECK,
        SSCR_APPLY_STATE,
        SSCR_APPLY_COND
    } sscr_setup_st_t;
endpackage

// ### logic/sscr_setup_check.sv
// Combinational validation of a latched setup command.
// Assumes the records are held stable by the caller while checked.
`timescale 1ns/1ps
module sscr_setup_check #(
    parameter int unsigned N_SUB = 8
) (
    input wire logic [15:0] handle_i,
    input wire logic [15:0] own_handle_i,
    input wire logic [7:0] count_i,
    input wire logic [N_SUB*sscr_pkg::REC_W-1:0] recs_i,
    output logic [7:0] rc_o
);
    logic [N_SUB-1:0] rec_bad;
    logic handle_bad;
    logic count_bad;

    // ========================================
    // Per-record field checks
    for (genvar i = 0; i < N_SUB; i++) begin : g_rec
        logic [7:0] cond;
        logic [7:0] init;
        logic [7:0] ntfy;
        assign cond = recs_i[i*sscr_pkg::REC_W+sscr_pkg::REC_COND_LSB +: 8];
        assign init = recs_i[i*sscr_pkg::REC_W+sscr_pkg::REC_INIT_LSB +: 8];
        assign ntfy = recs_i[i*sscr_pkg::REC_W+sscr_pkg::REC_NOTIFY_LSB +: 8];
        // Records past the count are not looked at
        assign rec_bad[i] = (count_i > 8'(i)) && (
            !(cond == sscr_pkg::OPC_ENABLED ||
              cond == sscr_pkg::OPC_DISABLED ||
              cond == sscr_pkg::OPC_UNAVAILABLE) ||
            (init == sscr_pkg::STATE_UNKNOWN) ||
            !(ntfy == sscr_pkg::NOTIFY_ON ||
              ntfy == sscr_pkg::NOTIFY_OFF ||
              ntfy == sscr_pkg::NOTIFY_KEEP));
    end

    assign handle_bad = (handle_i == sscr_pkg::HANDLE_RSVD_LO) ||
        (handle_i == sscr_pkg::HANDLE_RSVD_HI) ||
        (handle_i != own_handle_i);
    assign count_bad = (count_i < sscr_pkg::COUNT_MIN) ||
        (count_i > sscr_pkg::COUNT_MAX) || (count_i > 8'(N_SUB));

    always_comb begin
        if (handle_bad) begin
            rc_o = sscr_pkg::RC_UNKNOWN_HANDLE;
        end else if (count_bad || (|rec_bad)) begin
            rc_o = sscr_pkg::RC_INVALID_DATA;
        end else begin
            rc_o = sscr_pkg::RC_SUCCESS;
        end
    end
endmodule

// ### logic/sscr_sub_sensor.sv
// One sub-sensor: condition, current, prior and last-event state.
// Assumes setup pulses are single cycle and never overlap each other.
`timescale 1ns/1ps
module sscr_sub_sensor #(
    parameter bit VIRTUAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic assess_valid_i,
    input wire logic [7:0] assess_state_i,
    input wire logic set_state_i,
    input wire logic [7:0] init_state_i,
    input wire logic [7:0] notify_ctrl_i,
    input wire logic set_cond_i,
    input wire logic [7:0] cond_i,
    input wire logic rearm_i,
    output logic [7:0] cond_o,
    output logic [7:0] cur_o,
    output logic [7:0] prior_o,
    output logic [7:0] event_state_o,
    output logic event_o
);
    logic seen_q;
    logic prior_known_q;
    logic notify_en_q;
    logic new_valid;
    logic [7:0] new_state;
    logic restart;
    logic chg;
    logic ev;

    // Setup wins a same-cycle clash with the monitor path
    assign new_valid = set_state_i || (assess_valid_i && !VIRTUAL);
    assign new_state = set_state_i ? init_state_i : assess_state_i;
    // Virtual sensors take setup writes as assessments
    assign restart = set_state_i && !VIRTUAL;
    assign chg = new_valid && seen_q && !restart &&
        (new_state != cur_o);
    assign ev = chg && notify_en_q && (cond_o == sscr_pkg::OPC_ENABLED);

    // ========================================
    // State tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_o <= sscr_pkg::STATE_UNKNOWN;
            prior_o <= sscr_pkg::STATE_UNKNOWN;
            seen_q <= 1'b0;
            prior_known_q <= 1'b0;
        end else if (new_valid && (!seen_q || restart)) begin
            cur_o <= new_state;
            prior_o <= new_state;
            seen_q <= 1'b1;
            prior_known_q <= 1'b0;
        end else if (chg) begin
            prior_o <= cur_o;
            cur_o <= new_state;
            prior_known_q <= 1'b1;
        end
    end

    // ========================================
    // Event generation and setup fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_state_o <= sscr_pkg::STATE_UNKNOWN;
            event_o <= 1'b0;
        end else begin
            event_o <= ev;
            if (ev) begin
                event_state_o <= new_state;
            end else if (rearm_i) begin
                event_state_o <= sscr_pkg::STATE_UNKNOWN;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            notify_en_q <= sscr_pkg::RST_NOTIFY_EN;
        end else if (set_state_i && notify_ctrl_i != sscr_pkg::NOTIFY_KEEP) begin
            notify_en_q <= (notify_ctrl_i == sscr_pkg::NOTIFY_ON);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_o <= sscr_pkg::RST_COND;
        end else if (set_cond_i) begin
            cond_o <= cond_i;
        end
    end

    // ========================================
    // Checks
    AST_PRIOR_DIFFERS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        prior_known_q |-> prior_o != cur_o)
        else $error("prior state equals current state");
    AST_PRIOR_LOADS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        chg |=> prior_o == $past(cur_o) && cur_o == $past(new_state))
        else $error("prior state not loaded on change");
    AST_FIRST_EQUAL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        new_valid && !seen_q |=> prior_o == cur_o && !prior_known_q)
        else $error("first assessment left prior unequal");
    AST_EVENT_STATE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ev |=> event_o && event_state_o == $past(new_state))
        else $error("event state not captured");
    AST_KEEP_NOTIFY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        set_state_i && notify_ctrl_i == sscr_pkg::NOTIFY_KEEP
        |=> notify_en_q == $past(notify_en_q))
        else $error("keep setting altered notification");
endmodule

// ### logic/sscr_responder.sv
// Top of the state sensor command responder, with Wishbone slave.
// Assumes a classic Wishbone master and a synchronous monitor path.
`timescale 1ns/1ps
module sscr_responder #(
    parameter int unsigned N_SUB = 8,
    parameter logic [15:0] OWN_HANDLE = 16'h0001, // Arbitrary value
    parameter logic [7:0] VIRTUAL_MASK = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [N_SUB-1:0] assess_valid_i,
    input wire logic [N_SUB*8-1:0] assess_state_i,
    output logic [N_SUB-1:0] event_o,
    output logic busy_o
);
    localparam int unsigned RW = sscr_pkg::REC_W;

    if (N_SUB < 1 || N_SUB > sscr_pkg::NUM_SUB_MAX) begin : g_bad_nsub
        $error("N_SUB must lie in 1..8");
    end
    if (OWN_HANDLE == sscr_pkg::HANDLE_RSVD_LO ||
        OWN_HANDLE == sscr_pkg::HANDLE_RSVD_HI) begin : g_bad_handle
        $error("OWN_HANDLE must not be a reserved handle");
    end

    sscr_pkg::sscr_setup_st_t st_q;
    logic [15:0] handle_q;
    logic [7:0] count_q;
    logic [2:0] idx_q;
    logic [7:0] setup_rc_q;
    logic [7:0] read_rc_q;
    logic [RW-1:0] rec_q [N_SUB];
    logic [N_SUB*RW-1:0] recs_flat;
    logic [7:0] check_rc;
    logic [N_SUB-1:0] set_state_p;
    logic [N_SUB-1:0] set_cond_p;
    logic [N_SUB-1:0] rearm_p;
    logic [31:0] state_word [N_SUB];
    logic req;
    logic wr;
    logic [31:0] rd_d;
    logic [15:0] rd_handle;

    // ========================================
    // Bus slave: one wait state, ack for one cycle
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_d : 32'h0000_0000;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (wb_adr_i == sscr_pkg::ADDR_STATUS) begin
            rd_d[7:0] = setup_rc_q;
            rd_d[sscr_pkg::STATUS_BUSY_BIT] = busy_o;
            rd_d[sscr_pkg::STATUS_RDRC_LSB +: 8] = read_rc_q;
            rd_d[sscr_pkg::STATUS_NSUB_LSB +: 8] = 8'(N_SUB);
        end else if (wb_adr_i[7:5] == sscr_pkg::ADDR_REC_REGION &&
                     32'(wb_adr_i[4:2]) < N_SUB) begin
            rd_d[RW-1:0] = rec_q[wb_adr_i[4:2]];
        end else if (wb_adr_i[7:5] == sscr_pkg::ADDR_STATE_REGION &&
                     32'(wb_adr_i[4:2]) < N_SUB) begin
            rd_d = state_word[wb_adr_i[4:2]];
        end
    end

    // ========================================
    // Setup records, byte-lane writes refused while busy
    for (genvar i = 0; i < N_SUB; i++) begin : g_rec
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                rec_q[i] <= '0;
            end else if (wr && !busy_o && wb_adr_i ==
                         {sscr_pkg::ADDR_REC_REGION, 3'(i), 2'h0}) begin
                for (int b = 0; b < 3; b++) begin
                    if (wb_sel_i[b]) begin
                        rec_q[i][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                    end
                end
            end
        end
        assign recs_flat[i*RW +: RW] = rec_q[i];
    end

    sscr_setup_check #(
        .N_SUB(N_SUB)
    ) u_check (
        .handle_i(handle_q),
        .own_handle_i(OWN_HANDLE),
        .count_i(count_q),
        .recs_i(recs_flat),
        .rc_o(check_rc)
    );

    // ========================================
    // Setup command sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= sscr_pkg::SSCR_IDLE;
            handle_q <= 16'h0000;
            count_q <= 8'h00;
            idx_q <= 3'h0;
            setup_rc_q <= sscr_pkg::RC_SUCCESS;
            busy_o <= 1'b0;
        end else begin
            unique case (st_q)
                sscr_pkg::SSCR_IDLE: begin
                    if (wr && wb_adr_i == sscr_pkg::ADDR_SETUP_CMD &&
                        wb_sel_i == 4'hF &&
                        wb_dat_i[sscr_pkg::CMD_GO_BIT]) begin
                        handle_q <= wb_dat_i[15:0];
                        count_q <= wb_dat_i[sscr_pkg::CMD_COUNT_LSB +: 8];
                        busy_o <= 1'b1;
                        st_q <= sscr_pkg::SSCR_CHECK;
                    end
                end
                sscr_pkg::SSCR_CHECK: begin
                    setup_rc_q <= check_rc;
                    idx_q <= 3'h0;
                    if (check_rc == sscr_pkg::RC_SUCCESS) begin
                        st_q <= sscr_pkg::SSCR_APPLY_STATE;
                    end else begin
                        busy_o <= 1'b0;
                        st_q <= sscr_pkg::SSCR_IDLE;
                    end
                end
                sscr_pkg::SSCR_APPLY_STATE: begin
                    st_q <= sscr_pkg::SSCR_APPLY_COND;
                end
                sscr_pkg::SSCR_APPLY_COND: begin
                    if ({5'h00, idx_q} == count_q - 8'h01) begin
                        busy_o <= 1'b0;
                        st_q <= sscr_pkg::SSCR_IDLE;
                    end else begin
                        idx_q <= idx_q + 3'h1;
                        st_q <= sscr_pkg::SSCR_APPLY_STATE;
                    end
                end
            endcase
        end
    end

    // ========================================
    // Read command: handle check and rearm
    assign rd_handle = wb_dat_i[15:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_rc_q <= sscr_pkg::RC_SUCCESS;
            rearm_p <= '0;
        end else if (wr && wb_adr_i == sscr_pkg::ADDR_READ_CMD) begin
            if (rd_handle == sscr_pkg::HANDLE_RSVD_LO ||
                rd_handle == sscr_pkg::HANDLE_RSVD_HI ||
                rd_handle != OWN_HANDLE) begin
                read_rc_q <= sscr_pkg::RC_UNKNOWN_HANDLE;
                rearm_p <= '0;
            end else begin
                read_rc_q <= sscr_pkg::RC_SUCCESS;
                rearm_p <=
                    wb_dat_i[sscr_pkg::RDCMD_MASK_LSB +: N_SUB];
            end
        end else begin
            rearm_p <= '0;
        end
    end

    // ========================================
    // Sub-sensors
    for (genvar i = 0; i < N_SUB; i++) begin : g_sub
        logic [7:0] cond;
        logic [7:0] cur;
        logic [7:0] prior;
        logic [7:0] evs;
        assign set_state_p[i] = (st_q == sscr_pkg::SSCR_APPLY_STATE) &&
            (idx_q == 3'(i));
        assign set_cond_p[i] = (st_q == sscr_pkg::SSCR_APPLY_COND) &&
            (idx_q == 3'(i));
        sscr_sub_sensor #(
            .VIRTUAL(VIRTUAL_MASK[i])
        ) u_sub (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .assess_valid_i(assess_valid_i[i]),
            .assess_state_i(assess_state_i[i*8 +: 8]),
            .set_state_i(set_state_p[i]),
            .init_state_i(rec_q[i][sscr_pkg::REC_INIT_LSB +: 8]),
            .notify_ctrl_i(rec_q[i][sscr_pkg::REC_NOTIFY_LSB +: 8]),
            .set_cond_i(set_cond_p[i]),
            .cond_i(rec_q[i][sscr_pkg::REC_COND_LSB +: 8]),
            .rearm_i(rearm_p[i]),
            .cond_o(cond),
            .cur_o(cur),
            .prior_o(prior),
            .event_state_o(evs),
            .event_o(event_o[i])
        );
        assign state_word[i] = {evs, prior, cur, cond};
    end

    // ========================================
    // Checks
    AST_COND_AFTER_STATE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        |set_cond_p |-> $past(set_state_p) == set_cond_p)
        else $error("condition applied before state and notification");
    AST_START_AT_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_CHECK && check_rc == sscr_pkg::RC_SUCCESS
        |=> set_state_p[0] ##1 set_cond_p[0])
        else $error("setup did not start at offset zero");
    AST_UNKNOWN_HANDLE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_CHECK && handle_q != OWN_HANDLE
        |=> setup_rc_q == sscr_pkg::RC_UNKNOWN_HANDLE && !busy_o)
        else $error("unknown handle not answered with its code");
    AST_BAD_COUNT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_CHECK && handle_q == OWN_HANDLE &&
        (count_q == 8'h00 || count_q > 8'(N_SUB))
        |=> setup_rc_q == sscr_pkg::RC_INVALID_DATA && !busy_o)
        else $error("bad count accepted");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_FOLLOWS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    AST_DAT_IDLE_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside the ack cycle");
    AST_GO_STARTS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_IDLE && wr &&
        wb_adr_i == sscr_pkg::ADDR_SETUP_CMD && wb_sel_i == 4'hF &&
        wb_dat_i[sscr_pkg::CMD_GO_BIT]
        |=> busy_o && st_q == sscr_pkg::SSCR_CHECK)
        else $error("setup command did not start");

    // ========================================
    // Sequencing checks
    // Records must not move under the checker or the apply steps
    AST_RECS_FROZEN: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(busy_o) |-> $stable(recs_flat))
        else $error("setup record changed while busy");
    AST_NO_APPLY_ON_ERR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_CHECK && check_rc != sscr_pkg::RC_SUCCESS
        |=> (set_state_p == '0 && set_cond_p == '0)[*2])
        else $error("record applied after a refused setup");
    AST_ONE_SUB: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $onehot0(set_state_p) && $onehot0(set_cond_p))
        else $error("setup applied to two sub-sensors at once");
    AST_NEXT_OFFSET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_APPLY_COND && 8'(idx_q) + 8'h01 < count_q
        |=> st_q == sscr_pkg::SSCR_APPLY_STATE &&
            idx_q == $past(idx_q) + 3'h1)
        else $error("setup did not move to the next offset");
    AST_LAST_DONE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st_q == sscr_pkg::SSCR_APPLY_COND && 8'(idx_q) + 8'h01 == count_q
        |=> !busy_o && st_q == sscr_pkg::SSCR_IDLE)
        else $error("setup did not end after the last record");
    AST_READ_UNKNOWN: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == sscr_pkg::ADDR_READ_CMD && rd_handle != OWN_HANDLE
        |=> read_rc_q == sscr_pkg::RC_UNKNOWN_HANDLE && rearm_p == '0)
        else $error("read command accepted an unknown handle");
    AST_REARM_PULSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        |rearm_p |=> rearm_p == '0)
        else $error("rearm held longer than one cycle");
endmodule

// ### tb/sscr_assess_model.sv
// Model of the monitoring source that feeds state assessments.
// Assumes the bench asks for one assessment at a time via go_i.
`timescale 1ns/1ps
module sscr_assess_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [2:0] idx_i,
    input wire logic [7:0] st_i,
    input wire logic [3:0] dly_i,
    output logic [7:0] valid_o,
    output logic [63:0] state_o,
    output logic pend_o
);
    logic [3:0] cnt_q;
    logic [2:0] idx_q;
    logic [7:0] st_q;

    // ========================================
    // Delayed one-cycle assessment strobe
    always @(posedge clk_i) begin
        valid_o <= 8'h00;
        if (rst_i) begin
            pend_o <= 1'b0;
            state_o <= 64'h0;
        end else if (go_i) begin
            pend_o <= 1'b1;
            cnt_q <= dly_i;
            idx_q <= idx_i;
            st_q <= st_i;
        end else if (pend_o && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (pend_o) begin
            valid_o[idx_q] <= 1'b1;
            state_o[idx_q*8+:8] <= st_q;
            pend_o <= 1'b0;
        end else begin
            // Lines carry no value outside a strobe
            state_o <= ~state_o;
        end
    end
endmodule

// ### tb/tb.sv
// Self-checking bench for the state sensor command responder.
// Assumes eight sub-sensors, handle 0x0001, sub-sensor 1 virtual.
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [7:0] adr = 8'h00, ast = 8'h00, ev, av, rd_rc = 8'h00;
    logic [3:0] sel = 4'h0, dly = 4'h0;
    logic [2:0] aidx = 3'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [63:0] as;
    logic ack, busy, pend;
    logic [15:0] lfsr = 16'h004F;
    logic [31:0] exp_q[$];
    int fail_count = 0, comparisons = 0, ev_cnt = 0;

    initial forever #2.5 clk_i = ~clk_i;

    sscr_responder #(.VIRTUAL_MASK(8'h02)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .assess_valid_i(av), .assess_state_i(as), .event_o(ev),
        .busy_o(busy));
    sscr_assess_model src_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .idx_i(aidx), .st_i(ast), .dly_i(dly), .valid_o(av),
        .state_o(as), .pend_o(pend));

    // ========================================
    // Checking
    task automatic tally_and_finish();
        $display("counts: comparisons=%0d mismatches=%0d", comparisons,
            fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Read data is taken at the edge that samples ack high
    always @(posedge clk_i) begin
        ev_cnt += $countones(ev);
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("MISMATCH t=%0t got=%h exp=none", $time, rdat);
            end else begin
                chk(rdat, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // ========================================
    // Bus and stimulus tasks
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 64);
        if (ack !== 1'b1)
            fail_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic setup(input logic [15:0] h, input logic [7:0] n,
                         input logic [7:0] rc);
        int k;
        bus(1'b1, 8'h00, {1'b1, 7'h00, n, h});
        chk(busy, 32'h0000_0001);
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (busy !== 1'b0 && k < 64);
        if (busy !== 1'b0)
            fail_count++;
        rd(8'h04, {8'h08, rd_rc, 7'h00, 1'b0, rc});
    endtask

    task automatic assess(input logic [2:0] i, input logic [7:0] s,
                          input logic [3:0] d);
        int k;
        @(posedge clk_i);
        go <= 1'b1;
        aidx <= i;
        ast <= s;
        dly <= d;
        @(posedge clk_i);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (pend !== 1'b0 && k < 32);
        if (pend !== 1'b0)
            fail_count++;
        repeat (3) @(posedge clk_i);
    endtask

    // ========================================
    // Scenarios
    logic [15:0] bad_h[3] = '{16'h0000, 16'hFFFF, 16'h0002};
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h40, 32'h00000000);
        rd(8'h04, 32'h08000000);
        lfsr = lfsr_next(lfsr);
        bus(1'b1, 8'hF0, {lfsr, ~lfsr});
        rd(8'hF0, 32'h00000000);
        $display("test reset and map done");
        for (int i = 0; i < 3; i++)
            setup(bad_h[i], 8'h01, 8'h80);
        bus(1'b1, 8'h20, 32'h00010500);
        setup(16'h0001, 8'h00, 8'h02);
        setup(16'h0001, 8'h09, 8'h02);
        bus(1'b1, 8'h20, 32'h00010503);
        setup(16'h0001, 8'h01, 8'h02);
        bus(1'b1, 8'h20, 32'h00050500);
        setup(16'h0001, 8'h01, 8'h02);
        rd(8'h40, 32'h00000000);
        rd(8'h20, 32'h00050500);
        $display("test setup refusals done");
        bus(1'b1, 8'h20, 32'h00010500);
        bus(1'b1, 8'h24, 32'h00000701);
        setup(16'h0001, 8'h02, 8'h00);
        rd(8'h40, 32'h00050500);
        rd(8'h44, 32'h00070701);
        $display("test setup done");
        assess(3'h0, 8'h09, 4'h0);
        chk(ev_cnt, 1);
        rd(8'h40, 32'h09050900);
        assess(3'h0, 8'h09, 4'h5);
        chk(ev_cnt, 1);
        rd(8'h40, 32'h09050900);
        assess(3'h1, 8'h03, 4'h2);
        rd(8'h44, 32'h00070701);
        chk(ev_cnt, 1);
        $display("test assessments done");
        bus(1'b1, 8'h20, 32'h00FF0A00);
        bus(1'b1, 8'h24, 32'h00000801);
        setup(16'h0001, 8'h02, 8'h00);
        rd(8'h44, 32'h00070801);
        assess(3'h0, 8'h0B, 4'h1);
        chk(ev_cnt, 2);
        rd(8'h40, 32'h0B0A0B00);
        bus(1'b1, 8'h08, 32'h00010001);
        rd(8'h40, 32'h000A0B00);
        rd(8'h04, 32'h08000000);
        bus(1'b1, 8'h08, 32'h00010005);
        rd_rc = 8'h80;
        rd(8'h04, 32'h08800000);
        $display("test rearm and read command done");
        tally_and_finish();
    end
endmodule
